/* design/pin_irq_pkg.sv */
// constants for the external pin interrupt unit
package pin_irq_pkg;

  // =========================================================
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // =========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h2;

  // =========================================================
  // status/control bit positions
  localparam int PDD_BIT = 6;
  localparam int EDG_BIT = 5;
  localparam int PE_BIT = 4;
  localparam int FLAG_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int IE_BIT = 1;
  localparam int MOD_BIT = 0;

  // =========================================================
  // reset values and writable bits
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 8'h73;

  // =========================================================
  // event status layout
  localparam int EVT_W = 2;
  localparam int EVT_EDGE = 0;
  localparam int EVT_REFUSE = 1;
  localparam logic [EVT_W-1:0] STAT_RST = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;

endpackage

/* design/pin_irq_unit.sv */
// external pin interrupt unit: detection, pull control, wake, registers
`timescale 1ns/10ps
// Overview of operation
// - pin events ignored unless pin enabled
// - interrupt pin pull follows pull-disable bit
// - pull-up when falling polarity, else pull-down
// - keeps working in clocked stop modes
// - pin interrupt wakes from every stop mode
// - stop mode pin path is asynchronous
// - software selects falling/low or rising/high
// - software selects edge or edge plus level
// - register access follows the peripheral bus
// - active edge sets the detect flag
// - level mode holds flag while pin asserted
// - write one acknowledges, ack reads zero
// - IRQ_OUT and wake only when interrupt enabled; INT_OUT gated by event mask
module pin_irq_unit
  import pin_irq_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  // pin and pad control
  input wire logic PIN_IN,
  input wire logic PIN_FUNC_SEL_IN,
  input wire logic PORT_PULL_EN_IN,
  output logic PULL_EN_OUT,
  output logic PULL_UP_OUT,
  // power management
  input wire logic PCLK_EN_IN,
  input wire logic STOP_FC_IN,
  input wire logic STOP_SC_IN,
  input wire logic STOP_NC_IN,
  // requests
  output logic IRQ_OUT,
  output logic WAKE_OUT,
  output logic INT_OUT
);

  // =========================================================
  // helpers
  // pin level matches the selected polarity
  function automatic logic is_active(input logic lvl, input logic pol);
    is_active = (lvl == pol);
  endfunction

  // =========================================================
  // declarations
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_prev;
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] nxt_ctrl;
  logic flag_ff;
  logic nxt_flag;
  logic [EVT_W-1:0] stat_ff;
  logic [EVT_W-1:0] nxt_stat;
  logic [EVT_W-1:0] mask_ff;
  logic [EVT_W-1:0] nxt_mask;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [EVT_W-1:0] evt;
  logic run;
  logic stop_any;
  logic lvl_now;
  logic edge_det;
  logic flag_set;
  logic lvl_hold;
  logic wr_ctrl;
  logic ack;
  logic ack_ok;
  logic rd_stat;
  logic pin_en;
  logic pol;

  assign pin_en = ctrl_ff[PE_BIT];
  assign pol = ctrl_ff[EDG_BIT];
  assign stop_any = STOP_FC_IN | STOP_SC_IN | STOP_NC_IN;
  // clocked stop modes
  // no-clock stop freezes the clocked path; wake goes asynchronous
  assign run = PCLK_EN_IN & ~STOP_NC_IN;

  // =========================================================
  // pin synchroniser and edge detector
  // two-stage synchroniser
  always_comb begin
    nxt_sync1 = PIN_IN;
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
    end
  end

  // polarity select
  // a polarity change alone cannot look like an edge: sync2_ff and prev_ff are compared with the same pol
  assign lvl_now = is_active(sync2_ff, pol);
  assign edge_det = lvl_now & ~is_active(prev_ff, pol);

  // =========================================================
  // detect flag
  // pin enable gate
  assign flag_set = pin_en & run & edge_det;
  assign lvl_hold = ctrl_ff[MOD_BIT] & pin_en & lvl_now;
  assign wr_ctrl = WR_IN & (ADDR_IN == CTRL_OFS);
  assign ack = wr_ctrl & WDATA_IN[ACK_BIT];
  assign ack_ok = ack & ~lvl_hold;

  // write one clears
  // set wins over a same-cycle acknowledge
  always_comb begin
    nxt_flag = flag_set | (flag_ff & ~ack_ok);
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // =========================================================
  // control, mask and read data
  // register slave
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    if (wr_ctrl) begin
      nxt_ctrl = WDATA_IN & CTRL_WMASK;
    end else if (WR_IN && (ADDR_IN == MASK_OFS)) begin
      nxt_mask = WDATA_IN[EVT_W-1:0];
    end
  end

  // ack reads zero
  // unmapped offsets read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (RD_IN && (ADDR_IN == CTRL_OFS)) begin
      nxt_rdata = ctrl_ff;
      nxt_rdata[FLAG_BIT] = flag_ff;
      nxt_rdata[ACK_BIT] = 1'b0;
    end else if (RD_IN && (ADDR_IN == STAT_OFS)) begin
      nxt_rdata[EVT_W-1:0] = stat_ff;
    end else if (RD_IN && (ADDR_IN == MASK_OFS)) begin
      nxt_rdata[EVT_W-1:0] = mask_ff;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA_OUT = rdata_ff;

  // =========================================================
  // event status, read to clear
  assign evt[EVT_EDGE] = flag_set;
  assign evt[EVT_REFUSE] = ack & lvl_hold;
  assign rd_stat = RD_IN & (ADDR_IN == STAT_OFS);

  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++) begin : g_stat
      // event in the reading cycle survives for the next read
      always_comb begin
        nxt_stat[gi] = evt[gi] | (stat_ff[gi] & ~rd_stat);
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stat_ff <= STAT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign INT_OUT = |(stat_ff & mask_ff);

  // =========================================================
  // request, wake and pull outputs
  // enable gates request
  assign IRQ_OUT = flag_ff & ctrl_ff[IE_BIT];

  // asynchronous stop path
  // raw pin read on purpose: no clock may run to sample it
  assign WAKE_OUT = IRQ_OUT | (stop_any & pin_en & ctrl_ff[IE_BIT] &
                               is_active(PIN_IN, pol));

  assign PULL_EN_OUT = PIN_FUNC_SEL_IN ? ~ctrl_ff[PDD_BIT] : PORT_PULL_EN_IN;
  assign PULL_UP_OUT = PIN_FUNC_SEL_IN ? ~pol : 1'b1;

  // =========================================================
  // checks
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  chk_pin_gate: assert property (
    $rose(flag_ff) |-> $past(pin_en))
    else $error("flag rose with pin disabled");

  chk_pull_source: assert property (
    PULL_EN_OUT == (PIN_FUNC_SEL_IN ? !ctrl_ff[PDD_BIT] : PORT_PULL_EN_IN))
    else $error("pull enable from wrong source");

  chk_pull_dir: assert property (
    PIN_FUNC_SEL_IN && PULL_EN_OUT |-> PULL_UP_OUT != pol)
    else $error("pull direction wrong");

  chk_stop_run: assert property (
    (stop_any && PCLK_EN_IN && !STOP_NC_IN && pin_en && edge_det) |=> flag_ff)
    else $error("edge lost in clocked stop");

  chk_nc_frozen: assert property (
    STOP_NC_IN |=> !$rose(flag_ff))
    else $error("flag set without clock");

  chk_stop_wake: assert property (
    (stop_any && pin_en && ctrl_ff[IE_BIT] && PIN_IN == pol) |-> WAKE_OUT)
    else $error("no wake on active pin");

  chk_async_idle: assert property (
    (!stop_any && !IRQ_OUT) |-> !WAKE_OUT)
    else $error("wake outside stop");

  chk_polarity: assert property (
    flag_set |-> (sync2_ff == pol) && (prev_ff != pol))
    else $error("edge against polarity");

  chk_edge_only: assert property (
    (ack && !ctrl_ff[MOD_BIT] && !flag_set) |=> !flag_ff)
    else $error("ack ignored in edge mode");

  chk_edge_sets: assert property (
    flag_set |=> flag_ff ##1 flag_ff || $past(ack_ok))
    else $error("edge did not set flag");

  chk_level_hold: assert property (
    (flag_ff && lvl_hold) |=> flag_ff)
    else $error("flag dropped at level");

  chk_ack_zero: assert property (
    (RD_IN && ADDR_IN == CTRL_OFS) |=> !RDATA_OUT[ACK_BIT])
    else $error("ack read as one");

  chk_irq_gate: assert property (
    !ctrl_ff[IE_BIT] |-> !IRQ_OUT)
    else $error("request while disabled");

  chk_irq_rise: assert property (
    ($rose(flag_ff) && ctrl_ff[IE_BIT]) |-> IRQ_OUT)
    else $error("request missed");

  chk_sync_delay: assert property (
    edge_det |-> $past(PIN_IN, 2) != $past(PIN_IN, 3))
    else $error("edge not two stages late");

  chk_stat_read: assert property (
    (rd_stat && !evt[EVT_EDGE]) |=> !stat_ff[EVT_EDGE] &&
      RDATA_OUT[EVT_W-1:0] == $past(stat_ff))
    else $error("status read wrong");

  cov_edge_irq: cover property (flag_set ##1 IRQ_OUT);
  cov_level_refuse: cover property (evt[EVT_REFUSE]);
  cov_stop_wake: cover property (STOP_NC_IN && WAKE_OUT);
  cov_ack_clear: cover property (flag_ff ##1 ack_ok ##1 !flag_ff);

endmodule // pin_irq_unit

/* tb/pin_source.sv */
// far-side model: external device driving the interrupt pin
`timescale 1ns/10ps
module pin_source (
  // commands from the bench
  input wire logic drive_en_in,
  input wire logic drive_val_in,
  // pad pull seen from the unit
  input wire logic pull_en_in,
  input wire logic pull_up_in,
  // pad level
  output logic pin_out
);
  logic last_ff = 1'b1;
  always @(drive_en_in or drive_val_in) if (drive_en_in) last_ff = drive_val_in;
  // released pad follows pull
  // undriven and unpulled pad shows the inverse, never a stale level
  assign pin_out = drive_en_in ? drive_val_in : (pull_en_in ? pull_up_in : ~last_ff);
endmodule // pin_source

/* tb/pin_irq_unit_tb.sv */
// self-checking bench for the pin interrupt unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module pin_irq_unit_tb;
  import pin_irq_pkg::*;
  logic ck = 0, rst = 1, wr = 0, rd = 0, sel = 1, ppe = 0, pcen = 1;
  logic sfc = 0, ssc = 0, snc = 0, den = 1, dval = 1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0, rdata, d;
  logic pin, pull_en, pull_up, irq, wake, intr;
  int n_fail = 0, checks_done = 0;
  // ==========================================================
  // clock, instances
  always #5 ck = ~ck;
  pin_source pin_source_i (.drive_en_in(den), .drive_val_in(dval), .pull_en_in(pull_en),
    .pull_up_in(pull_up), .pin_out(pin));
  pin_irq_unit pin_irq_unit_i (.REF_CLK_IN(ck), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin), .PIN_FUNC_SEL_IN(sel),
    .PORT_PULL_EN_IN(ppe), .PULL_EN_OUT(pull_en), .PULL_UP_OUT(pull_up),
    .PCLK_EN_IN(pcen), .STOP_FC_IN(sfc), .STOP_SC_IN(ssc), .STOP_NC_IN(snc),
    .IRQ_OUT(irq), .WAKE_OUT(wake), .INT_OUT(intr));
  // ==========================================================
  // bus and pin helpers
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ck); wr <= 1'b1; addr <= a; wd <= v;
    @(posedge ck); wr <= 1'b0;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge ck); rd <= 1'b1; addr <= a;
    @(posedge ck); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic drive(input logic v, input int n);
    @(posedge ck); dval <= v;
    repeat (n) @(posedge ck);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rreg(CTRL_OFS, d); `CHK("ctrl reset", CTRL_RST, d)
    rreg(4'hF, d); `CHK("unmapped", 8'h00, d)
    `CHK("pull up reset", 1'b1, pull_up)
    $display("test reset done");
  endtask
  task automatic t_disabled();
    wreg(CTRL_OFS, 8'h02); drive(1'b0, 4);
    rreg(CTRL_OFS, d); `CHK("flag off", 8'h02, d)
    `CHK("irq off", 1'b0, irq)
    drive(1'b1, 4);
    $display("test disabled done");
  endtask
  task automatic t_edge();
    wreg(MASK_OFS, 8'h01); wreg(CTRL_OFS, 8'h12); drive(1'b0, 4);
    `CHK("irq edge", 1'b1, irq)
    `CHK("int edge", 1'b1, intr)
    rreg(CTRL_OFS, d); `CHK("flag set", 8'h1A, d)
    rreg(STAT_OFS, d); `CHK("status", 8'h01, d)
    `CHK("int cleared", 1'b0, intr)
    wreg(CTRL_OFS, 8'h10); #1 `CHK("irq masked", 1'b0, irq)
    wreg(CTRL_OFS, 8'h16); rreg(CTRL_OFS, d); `CHK("ack", 8'h12, d)
    $display("test edge done");
  endtask
  task automatic t_level();
    wreg(CTRL_OFS, 8'h23); wreg(CTRL_OFS, 8'h33); drive(1'b1, 4);
    rreg(CTRL_OFS, d); `CHK("rise flag", 8'h3B, d)
    wreg(CTRL_OFS, 8'h37); rreg(CTRL_OFS, d); `CHK("ack held", 8'h3B, d)
    rreg(STAT_OFS, d); `CHK("refused", 8'h03, d)
    drive(1'b0, 4); wreg(CTRL_OFS, 8'h37);
    rreg(CTRL_OFS, d); `CHK("ack low", 8'h33, d)
    $display("test level done");
  endtask
  task automatic t_stop();
    wreg(CTRL_OFS, 8'h02); wreg(CTRL_OFS, 8'h12); drive(1'b1, 4);
    @(posedge ck); snc <= 1'b1;
    #1 `CHK("wake idle", 1'b0, wake)
    drive(1'b0, 0);
    `CHK("wake async", 1'b1, wake)
    repeat (4) @(posedge ck);
    rreg(CTRL_OFS, d); `CHK("nc no flag", 8'h12, d)
    drive(1'b1, 4);
    @(posedge ck); snc <= 1'b0; sfc <= 1'b1;
    drive(1'b0, 4);
    `CHK("fc irq", 1'b1, irq)
    wreg(CTRL_OFS, 8'h16); sfc <= 1'b0; ssc <= 1'b1; pcen <= 1'b0;
    // clock enable off: edge must be lost, wake must not
    drive(1'b1, 4); drive(1'b0, 4);
    `CHK("gated irq", 1'b0, irq)
    `CHK("sc wake", 1'b1, wake)
    @(posedge ck); pcen <= 1'b1;
    drive(1'b1, 4); drive(1'b0, 4);
    `CHK("sc irq", 1'b1, irq)
    wreg(CTRL_OFS, 8'h16); ssc <= 1'b0;
    $display("test stop done");
  endtask
  task automatic t_pull();
    wreg(CTRL_OFS, 8'h00); den <= 1'b0; #1 `CHK("pull en", 1'b1, pull_en)
    `CHK("pull up", 1'b1, pull_up)
    `CHK("pad high", 1'b1, pin)
    wreg(CTRL_OFS, 8'h20); #1 `CHK("pull down", 1'b0, pull_up)
    `CHK("pad low", 1'b0, pin)
    wreg(CTRL_OFS, 8'h40); #1 `CHK("pull off", 1'b0, pull_en)
    @(posedge ck); sel <= 1'b0; ppe <= 1'b1; #1 `CHK("port pull", 1'b1, pull_en)
    $display("test pull done");
  endtask
  // ==========================================================
  // closing
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge ck);
    rst <= 1'b0;
    t_reset();
    t_disabled();
    t_edge();
    t_level();
    t_stop();
    t_pull();
    complete_run();
  end
endmodule // pin_irq_unit_tb
